// *** uartlc_top.sv ***
// Implementation choice: strobed register access.
`include "uartlc_regs.svh"
// Functional notes
// - full-duplex serial to parallel and back
// - receive and transmit on two general pins
// - rate is clock over 2^cd*16*2*divisor
// - divisor is 16 bits, low and high bytes
// - fractional stage multiplies by m plus n/2048
// - latch access bit swaps data for divisor low
// - second address is irq enable or divisor high
// - tx byte write-only queued, rx byte read-only
// - break bit holds transmit line low unless loopback is on
// - parity enable adds and checks parity
// - even select chooses even or odd parity
// - stick parity forces bit to even select
// - stop bit: 1.5 for five bits, else 2
// - receiver checks only the first stop bit
// - word length codes give 5 to 8 bits
// - holding-empty and data-ready set and clear
// - identity reports highest pending source
// - fractional enable selects fractional divider
// - loopback forces tx high; input selector
module uartlc_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  // serial pins
  input wire logic gpio_rx_i,
  input wire logic lin_rx_i,
  output logic gpio_tx_o,
  // core clock divide setting
  input wire logic [2:0] core_clock_divide_i
);
  uartlc_pkg::uartlc_top_state_type s;
  uartlc_pkg::uartlc_top_state_type n;
  logic tick16;
  logic divisor_access_select;
  logic rx_in;
  logic tx_fully_empty;
  logic [7:0] iid_value;
  logic [2:0] last_bit;
  logic [5:0] stop_last;
  logic [7:0] tx_masked;
  logic [7:0] rx_aligned;
  logic rx_expect;
  logic tx_loaded;
  logic rx_done;

  uartlc_baud u_baud (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .core_clock_divide_i(core_clock_divide_i),
    .divisor_value_i(s.div),
    .fractional_enable_i(s.frac[`UARTLC_FRACTIONAL_ENABLE]),
    .frac_m_i(s.frac[`UARTLC_M_HI:`UARTLC_M_LO]),
    .frac_n_i(s.frac[`UARTLC_N_HI:0]),
    .tick16_o(tick16)
  );

  // derived views of the current state
  assign divisor_access_select = s.lcr[`UARTLC_DIVISOR_ACCESS_SELECT];
  assign tx_fully_empty = s.tx_holding_empty && (s.tx_st == uartlc_pkg::TX_IDLE);
  assign last_bit = 3'h4 + {1'b0, s.lcr[1:0]};
  assign rx_aligned = s.rx_shift >> (2'h3 - s.lcr[1:0]);
  // internal loop lets software test the path while the pin idles high
  assign rx_in = s.loop ? s.tx_line :
                 (s.in_sel == `UARTLC_SEL_GPIO) ? gpio_rx_i : lin_rx_i;
  assign rx_expect = s.lcr[`UARTLC_SP] ? s.lcr[`UARTLC_EPS] :
                     (s.lcr[`UARTLC_EPS] ? s.rx_par : !s.rx_par);

  // stop length in ticks minus one
  always_comb begin
    if (!s.lcr[`UARTLC_STOP]) begin
      stop_last = `UARTLC_STOP_ONE_LAST;
    end else if (s.lcr[1:0] == 2'h0) begin
      stop_last = `UARTLC_STOP_HALF_LAST;
    end else begin
      stop_last = `UARTLC_STOP_TWO_LAST;
    end
  end

  // unused high data bits drop out of the parity sum
  always_comb begin
    case (s.lcr[1:0])
      2'h0: tx_masked = s.tx_hold & 8'h1f;
      2'h1: tx_masked = s.tx_hold & 8'h3f;
      2'h2: tx_masked = s.tx_hold & 8'h7f;
      default: tx_masked = s.tx_hold;
    endcase
  end

  // priority encoder for the identity register
  always_comb begin
    if (s.ier[`UARTLC_ELSI] && (s.oe || s.pe || s.fe)) begin
      iid_value = `UARTLC_IID_LINE;
    end else if (s.ier[`UARTLC_ERBFI] && s.dr) begin
      iid_value = `UARTLC_IID_RXF;
    end else if (s.ier[`UARTLC_ETBEI] && s.tx_holding_empty_pend) begin
      iid_value = `UARTLC_IID_TXE;
    end else begin
      iid_value = `UARTLC_IID_NONE;
    end
  end

  // next state: transmitter, then register port, then receiver
  always_comb begin
    n = s;
    n.rd_data = 16'h0000;
    tx_loaded = 1'b0;
    rx_done = 1'b0;
    // transmitter runs independently of the receiver
    if (tick16) begin
      case (s.tx_st)
        uartlc_pkg::TX_IDLE: begin
          if (!s.tx_holding_empty) begin
            n.tx_shift = s.tx_hold;
            n.tx_par = s.lcr[`UARTLC_SP] ? s.lcr[`UARTLC_EPS] :
                       (s.lcr[`UARTLC_EPS] ? ^tx_masked : ~^tx_masked);
            n.tx_holding_empty = 1'b1;
            tx_loaded = 1'b1;
            n.tx_st = uartlc_pkg::TX_START;
            n.tx_tick = 6'h00;
          end
        end
        uartlc_pkg::TX_START: begin
          n.tx_tick = s.tx_tick + 6'h01;
          if (s.tx_tick == `UARTLC_TICK_LAST) begin
            n.tx_tick = 6'h00;
            n.tx_bit = 3'h0;
            n.tx_st = uartlc_pkg::TX_DATA;
          end
        end
        uartlc_pkg::TX_DATA: begin
          n.tx_tick = s.tx_tick + 6'h01;
          if (s.tx_tick == `UARTLC_TICK_LAST) begin
            n.tx_tick = 6'h00;
            n.tx_shift = {1'b0, s.tx_shift[7:1]}; // lsb first
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_bit == last_bit) begin
              n.tx_st = s.lcr[`UARTLC_PEN] ? uartlc_pkg::TX_PARITY :
                        uartlc_pkg::TX_STOP;
            end
          end
        end
        uartlc_pkg::TX_PARITY: begin
          n.tx_tick = s.tx_tick + 6'h01;
          if (s.tx_tick == `UARTLC_TICK_LAST) begin
            n.tx_tick = 6'h00;
            n.tx_st = uartlc_pkg::TX_STOP;
          end
        end
        uartlc_pkg::TX_STOP: begin
          n.tx_tick = s.tx_tick + 6'h01;
          if (s.tx_tick >= stop_last) begin
            n.tx_tick = 6'h00;
            n.tx_st = uartlc_pkg::TX_IDLE;
          end
        end
        default: begin
          n.tx_st = uartlc_pkg::TX_IDLE;
        end
      endcase
    end
    // serial level before break and loopback forcing
    case (n.tx_st)
      uartlc_pkg::TX_START: n.tx_line = 1'b0;
      uartlc_pkg::TX_DATA: n.tx_line = n.tx_shift[0];
      uartlc_pkg::TX_PARITY: n.tx_line = n.tx_par;
      default: n.tx_line = 1'b1;
    endcase

    // register writes; a data write after a load keeps the new byte
    if (reg_write_i) begin
      case (reg_addr_i)
        `UARTLC_ADDR_DATA: begin
          if (divisor_access_select) begin
            n.div[7:0] = reg_wdata_i[7:0];
          end else begin
            n.tx_hold = reg_wdata_i[7:0];
            n.tx_holding_empty = 1'b0;
            n.tx_holding_empty_pend = 1'b0;
          end
        end
        `UARTLC_ADDR_IER: begin
          if (divisor_access_select) begin
            n.div[15:8] = reg_wdata_i[7:0];
          end else begin
            n.ier = reg_wdata_i[2:0];
          end
        end
        `UARTLC_ADDR_LCR: n.lcr = reg_wdata_i[7:0];
        `UARTLC_ADDR_CON1: begin
          n.in_sel = reg_wdata_i[`UARTLC_SEL_HI:`UARTLC_SEL_LO];
          n.loop = reg_wdata_i[`UARTLC_LOOP];
        end
        `UARTLC_ADDR_FRAC: n.frac = reg_wdata_i;
        default: begin
        end
      endcase
    end

    // register reads and their clearing side effects
    if (reg_read_i) begin
      case (reg_addr_i)
        `UARTLC_ADDR_DATA: begin
          if (divisor_access_select) begin
            n.rd_data = {8'h00, s.div[7:0]};
          end else begin
            n.rd_data = {8'h00, s.rx_byte};
            n.dr = 1'b0;
          end
        end
        `UARTLC_ADDR_IER: n.rd_data = divisor_access_select ? {8'h00, s.div[15:8]} : {13'h0000, s.ier};
        `UARTLC_ADDR_IID: begin
          n.rd_data = {8'h00, iid_value};
          if (iid_value == `UARTLC_IID_TXE) begin
            n.tx_holding_empty_pend = 1'b0;
          end
        end
        `UARTLC_ADDR_LCR: n.rd_data = {8'h00, s.lcr};
        `UARTLC_ADDR_CON1: n.rd_data = {8'h00, s.in_sel, 1'b0, s.loop, 4'h0};
        `UARTLC_ADDR_STA: begin
          n.rd_data = {8'h00, 1'b0, tx_fully_empty, s.tx_holding_empty, s.bi, s.fe, s.pe, s.oe, s.dr};
          n.bi = 1'b0;
          n.fe = 1'b0;
          n.pe = 1'b0;
          n.oe = 1'b0;
        end
        `UARTLC_ADDR_FRAC: n.rd_data = s.frac;
        default: n.rd_data = 16'h0000;
      endcase
    end
    // a new empty event outranks an identity read in the same cycle
    if (tx_loaded && n.tx_holding_empty) begin
      n.tx_holding_empty_pend = 1'b1;
    end

    // receiver: hardware sets are applied last so they win over clears
    if (tick16) begin
      case (s.rx_st)
        uartlc_pkg::RX_IDLE: begin
          if (!rx_in) begin
            n.rx_st = uartlc_pkg::RX_START;
            n.rx_tick = 6'h00;
          end
        end
        uartlc_pkg::RX_START: begin
          n.rx_tick = s.rx_tick + 6'h01;
          if (s.rx_tick == `UARTLC_TICK_HALF) begin
            // a glitch shorter than half a bit is not a start
            n.rx_st = rx_in ? uartlc_pkg::RX_IDLE : uartlc_pkg::RX_DATA;
            n.rx_tick = 6'h00;
            n.rx_bit = 3'h0;
            n.rx_par = 1'b0;
            n.rx_zero = 1'b1;
          end
        end
        uartlc_pkg::RX_DATA: begin
          n.rx_tick = s.rx_tick + 6'h01;
          if (s.rx_tick == `UARTLC_TICK_LAST) begin
            n.rx_tick = 6'h00;
            n.rx_shift = {rx_in, s.rx_shift[7:1]};
            n.rx_par = s.rx_par ^ rx_in;
            n.rx_zero = s.rx_zero && !rx_in;
            n.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == last_bit) begin
              n.rx_st = s.lcr[`UARTLC_PEN] ? uartlc_pkg::RX_PARITY :
                        uartlc_pkg::RX_STOP;
              n.rx_perr = 1'b0;
            end
          end
        end
        uartlc_pkg::RX_PARITY: begin
          n.rx_tick = s.rx_tick + 6'h01;
          if (s.rx_tick == `UARTLC_TICK_LAST) begin
            n.rx_tick = 6'h00;
            n.rx_perr = (rx_in != rx_expect);
            n.rx_zero = s.rx_zero && !rx_in;
            n.rx_st = uartlc_pkg::RX_STOP;
          end
        end
        uartlc_pkg::RX_STOP: begin
          n.rx_tick = s.rx_tick + 6'h01;
          if (s.rx_tick == `UARTLC_TICK_LAST) begin
            // only the first stop bit is looked at
            rx_done = 1'b1;
            n.rx_byte = rx_aligned;
            // a same-cycle data read is no overrun, a same-cycle status read clears first
            n.oe = n.oe || n.dr;
            n.dr = 1'b1;
            n.fe = n.fe || !rx_in;
            n.pe = n.pe || s.rx_perr;
            n.bi = n.bi || (s.rx_zero && !rx_in);
            n.rx_tick = 6'h00;
            // a held-low line must rise before the next start is sought
            n.rx_st = rx_in ? uartlc_pkg::RX_IDLE : uartlc_pkg::RX_WAIT_HIGH;
          end
        end
        uartlc_pkg::RX_WAIT_HIGH: begin
          if (rx_in) begin
            n.rx_st = uartlc_pkg::RX_IDLE;
          end
        end
        default: begin
          n.rx_st = uartlc_pkg::RX_IDLE;
        end
      endcase
    end

    // pin forcing uses the settings that take effect this edge
    if (n.loop) begin
      n.tx_pin = 1'b1;
    end else if (n.lcr[`UARTLC_BRK]) begin
      n.tx_pin = 1'b0;
    end else begin
      n.tx_pin = n.tx_line;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.tx_holding_empty <= 1'b1;
      s.tx_line <= 1'b1;
      s.tx_pin <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_o = s.rd_data;
  assign gpio_tx_o = s.tx_pin;

  // ticks spent in the stop state, for checking only
  logic [5:0] chk_stop_ticks;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chk_stop_ticks <= 6'h00;
    end else if (s.tx_st != uartlc_pkg::TX_STOP) begin
      chk_stop_ticks <= 6'h00;
    end else if (tick16) begin
      chk_stop_ticks <= chk_stop_ticks + 6'h01;
    end
  end

  default clocking chk_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence rx_read_seq;
    reg_read_i && (reg_addr_i == `UARTLC_ADDR_DATA) && !divisor_access_select;
  endsequence
  sequence tx_write_seq;
    reg_write_i && (reg_addr_i == `UARTLC_ADDR_DATA) && !divisor_access_select;
  endsequence

  break_hold_a: assert property (s.lcr[`UARTLC_BRK] && !s.loop |-> !gpio_tx_o)
    else $error("break does not hold the line low");
  loop_high_a: assert property (s.loop |-> gpio_tx_o)
    else $error("loopback does not force the pin high");
  rx_read_data_a: assert property (rx_read_seq |=> reg_rdata_o == {8'h00, $past(s.rx_byte)})
    else $error("receive byte read returns wrong data");
  ready_clear_a: assert property (rx_read_seq and !rx_done |=> !s.dr)
    else $error("data ready not cleared by read");
  tx_holding_empty_clear_a: assert property (tx_write_seq |=> !s.tx_holding_empty ##1 1)
    else $error("holding empty not cleared by write");
  div_access_a: assert property (reg_write_i && (reg_addr_i == `UARTLC_ADDR_DATA) && divisor_access_select
    |=> s.div[7:0] == $past(reg_wdata_i[7:0]) && $stable(s.tx_hold))
    else $error("divisor low write misrouted");
  irq_prio_a: assert property (s.ier[`UARTLC_ELSI] && s.fe
    |-> iid_value == `UARTLC_IID_LINE)
    else $error("line status not reported first");
  start_low_a: assert property (s.tx_st == uartlc_pkg::TX_START && !s.loop
    && !s.lcr[`UARTLC_BRK] |-> !gpio_tx_o)
    else $error("start bit not low");
  stick_bit_a: assert property (s.tx_st == uartlc_pkg::TX_PARITY && s.lcr[`UARTLC_SP]
    && !s.loop && !s.lcr[`UARTLC_BRK] |-> gpio_tx_o == s.lcr[`UARTLC_EPS])
    else $error("stick parity bit wrong");
  stop_len_a: assert property (s.tx_st == uartlc_pkg::TX_STOP && n.tx_st == uartlc_pkg::TX_IDLE
    |-> chk_stop_ticks == (!s.lcr[`UARTLC_STOP] ? 6'h0f :
        (s.lcr[1:0] == 2'h0) ? 6'h17 : 6'h1f))
    else $error("stop length wrong");
endmodule // uartlc_top

// *** uartlc_regs.svh ***
`ifndef UARTLC_REGS_SVH
`define UARTLC_REGS_SVH
// register byte addresses
`define UARTLC_ADDR_DATA 32'hffff0700
`define UARTLC_ADDR_IER 32'hffff0704
`define UARTLC_ADDR_IID 32'hffff0708
`define UARTLC_ADDR_LCR 32'hffff070c
`define UARTLC_ADDR_CON1 32'hffff0710
`define UARTLC_ADDR_STA 32'hffff0714
`define UARTLC_ADDR_FRAC 32'hffff072c
// line_format_control bit positions
`define UARTLC_DIVISOR_ACCESS_SELECT 7
`define UARTLC_BRK 6
`define UARTLC_SP 5
`define UARTLC_EPS 4
`define UARTLC_PEN 3
`define UARTLC_STOP 2
// input_select_control fields
`define UARTLC_LOOP 4
`define UARTLC_SEL_HI 7
`define UARTLC_SEL_LO 6
`define UARTLC_SEL_GPIO 2'h2
// fractional_rate_control fields
`define UARTLC_FRACTIONAL_ENABLE 15
`define UARTLC_M_HI 12
`define UARTLC_M_LO 11
`define UARTLC_N_HI 10
// serial_irq_enable bit positions
`define UARTLC_ELSI 2
`define UARTLC_ETBEI 1
`define UARTLC_ERBFI 0
// serial_irq_identity codes
`define UARTLC_IID_NONE 8'h01
`define UARTLC_IID_LINE 8'h06
`define UARTLC_IID_RXF 8'h04
`define UARTLC_IID_TXE 8'h02
// timing counts in sixteenth-bit ticks
`define UARTLC_TICK_LAST 6'h0f
`define UARTLC_TICK_HALF 6'h07
`define UARTLC_STOP_ONE_LAST 6'h0f
`define UARTLC_STOP_HALF_LAST 6'h17
`define UARTLC_STOP_TWO_LAST 6'h1f
// fixed divide by two ahead of the divisor latch
`define UARTLC_PRE_FACTOR 9'h002
`endif

// *** uartlc_pkg.sv ***
package uartlc_pkg;
  // transmitter states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP = 3'b100
  } uartlc_tx_state_type;
  // receiver states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP = 3'b100,
    RX_WAIT_HIGH = 3'b101
  } uartlc_rx_state_type;
  // all state of the top module
  typedef struct packed {
    logic [7:0] lcr;
    logic [2:0] ier;
    logic [1:0] in_sel;
    logic loop;
    logic [15:0] div;
    logic [15:0] frac;
    logic [7:0] tx_hold;
    logic tx_holding_empty;
    logic tx_holding_empty_pend;
    uartlc_tx_state_type tx_st;
    logic [7:0] tx_shift;
    logic tx_par;
    logic [5:0] tx_tick;
    logic [2:0] tx_bit;
    logic tx_line;
    logic tx_pin;
    uartlc_rx_state_type rx_st;
    logic [5:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
    logic rx_zero;
    logic rx_perr;
    logic [7:0] rx_byte;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [15:0] rd_data;
  } uartlc_top_state_type;
  // all state of the rate generator
  typedef struct packed {
    logic [8:0] pre_cnt;
    logic [15:0] dl_cnt;
    logic [1:0] m_cnt;
    logic [10:0] acc;
    logic extra;
    logic tick;
  } uartlc_baud_state_type;
endpackage

// *** uartlc_baud.sv ***
`include "uartlc_regs.svh"
module uartlc_baud (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // rate settings
  input wire logic [2:0] core_clock_divide_i,
  input wire logic [15:0] divisor_value_i,
  input wire logic fractional_enable_i,
  input wire logic [1:0] frac_m_i,
  input wire logic [10:0] frac_n_i,
  // sixteen-times bit rate enable
  output logic tick16_o
);
  uartlc_pkg::uartlc_baud_state_type s;
  uartlc_pkg::uartlc_baud_state_type n;
  logic [8:0] pre_last;
  logic [15:0] dl_last;
  logic [1:0] m_last;
  logic [11:0] acc_sum;

  // prescale by 2^cd * 2, then divisor, then optional m + n/2048 stage
  always_comb begin
    n = s;
    n.tick = 1'b0;
    pre_last = (`UARTLC_PRE_FACTOR << core_clock_divide_i) - 9'h001;
    // a zero divisor or zero m would stall the line, so they act as one
    dl_last = (divisor_value_i == 16'h0000) ? 16'h0000 : divisor_value_i - 16'h0001;
    m_last = (frac_m_i == 2'h0) ? 2'h0 : frac_m_i - 2'h1;
    acc_sum = {1'b0, s.acc} + {1'b0, frac_n_i};
    if (s.pre_cnt >= pre_last) begin
      n.pre_cnt = 9'h000;
      if (s.dl_cnt >= dl_last) begin
        n.dl_cnt = 16'h0000;
        if (!fractional_enable_i) begin
          n.tick = 1'b1;
        end else if (s.extra) begin
          n.extra = 1'b0; // stretch by one divisor period on carry
        end else if (s.m_cnt >= m_last) begin
          n.m_cnt = 2'h0;
          n.tick = 1'b1;
          n.acc = acc_sum[10:0];
          n.extra = acc_sum[11];
        end else begin
          n.m_cnt = s.m_cnt + 2'h1;
        end
      end else begin
        n.dl_cnt = s.dl_cnt + 16'h0001;
      end
    end else begin
      n.pre_cnt = s.pre_cnt + 9'h001;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick16_o = s.tick;
endmodule // uartlc_baud

// *** uartlc_peer.sv ***
module uartlc_peer (
  // clock
  input wire logic clk_sys_i,
  // serial lines seen from the peer side
  input wire logic line_in_i,
  output logic line_out_o,
  // capture length and captured bits
  input wire logic [3:0] bits_i,
  output logic [15:0] got_o,
  output logic got_v_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // divide by two, divisor one, sixteen ticks a bit
  localparam int BIT_CLKS = 32;
  initial begin
    line_out_o = 1'b1;
    got_o = 16'h0000;
    got_v_o = 1'b0;
  end
  // send one character lsb first; the line idles high afterwards
  task automatic send(input logic [15:0] f, input int n);
    line_out_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      line_out_o <= f[i];
      repeat (BIT_CLKS) @(posedge clk_sys_i);
    end
    line_out_o <= 1'b1;
  endtask
  // sample mid-cell; zero length ignores the line, e.g. during a break
  always begin
    @(negedge line_in_i);
    if (bits_i != 4'h0) begin
      repeat (BIT_CLKS / 2) @(posedge clk_sys_i);
      got_o = 16'h0000;
      for (int i = 0; i < bits_i; i++) begin
        repeat (BIT_CLKS) @(posedge clk_sys_i);
        got_o[i] = line_in_i;
      end
      // valid strobe sits between edges so the watcher sees it once
      @(negedge clk_sys_i);
      got_v_o = 1'b1;
      @(negedge clk_sys_i);
      got_v_o = 1'b0;
    end
  end
endmodule // uartlc_peer

// *** testbench.sv ***
`include "uartlc_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [31:0] reg_addr_i = 32'h00000000;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic gpio_rx_i;
  logic lin_rx_i = 1'b1;
  logic gpio_tx_o;
  logic [2:0] core_clock_divide_i = 3'h0;
  logic [3:0] bits = 4'h0;
  logic [15:0] got;
  logic got_v;
  logic rd_seen = 1'b0;
  logic [15:0] rq[$];
  logic [15:0] fq[$];
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] r = 8'h09;
  logic [7:0] lc;
  logic [15:0] f;

  uartlc_top dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .gpio_rx_i(gpio_rx_i), .lin_rx_i(lin_rx_i),
    .gpio_tx_o(gpio_tx_o), .core_clock_divide_i(core_clock_divide_i));
  uartlc_peer peer_u (.clk_sys_i(clk_sys_i), .line_in_i(gpio_tx_o), .line_out_o(gpio_rx_i),
    .bits_i(bits), .got_o(got), .got_v_o(got_v));

  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // bits after the start bit: data, parity, first stop
  function automatic logic [3:0] nb(input logic [7:0] c);
    return 4'(6 + c[1:0] + c[3]);
  endfunction
  // expected character, lsb first from bit 0; pf flips parity, sv is the stop level
  function automatic logic [15:0] frame_of(input logic [7:0] c, input logic [7:0] d,
      input logic pf, input logic sv);
    int w;
    logic p;
    w = 5 + c[1:0];
    d = d & 8'((9'h001 << w) - 9'h001);
    p = c[5] ? c[4] : ~(c[4] ^ (^d));
    return {8'h00, d} | ((16'(p ^ pf) & {16{c[3]}}) << w) | (16'(sv) << (w + c[3]));
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobes stay up between calls so back-to-back cycles never drop them
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    reg_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    reg_write_i <= 1'b0;
    rq.push_back(e);
    @(posedge clk_sys_i);
  endtask
  task automatic hold(input int n);
    reg_write_i <= 1'b0;
    reg_read_i <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // compare each answer with the oldest note
  always @(posedge clk_sys_i) begin
    if (rd_seen) check("reg read", reg_rdata_o, rq.pop_front());
    if (got_v) check("tx frame", got, fq.pop_front());
    rd_seen <= reg_read_i;
  end

  // cut a hang short; the tests need well under this many cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // reset values, an unmapped place, then the shared addresses
    rd(`UARTLC_ADDR_STA, 16'h0060);
    rd(`UARTLC_ADDR_IID, 16'h0001);
    rd(`UARTLC_ADDR_LCR, 16'h0000);
    rd(32'hffff07f0, 16'h0000);
    wr(`UARTLC_ADDR_LCR, 16'h0080);
    rd(`UARTLC_ADDR_DATA, 16'h0000);
    wr(`UARTLC_ADDR_IER, 16'h00a5);
    wr(`UARTLC_ADDR_DATA, 16'h0001);
    rd(`UARTLC_ADDR_IER, 16'h00a5);
    rd(`UARTLC_ADDR_DATA, 16'h0001);
    wr(`UARTLC_ADDR_IER, 16'h0000);
    wr(`UARTLC_ADDR_LCR, 16'h0000);
    rd(`UARTLC_ADDR_IER, 16'h0000);
    wr(`UARTLC_ADDR_IER, 16'h0002);
    rd(`UARTLC_ADDR_IER, 16'h0002);
    // fractional path with m one and n zero must keep the plain bit time
    wr(`UARTLC_ADDR_FRAC, 16'h8800);
    rd(`UARTLC_ADDR_FRAC, 16'h8800);
    hold(1);
    $display("test registers done");
    // every word length; parity and stop settings random, stick and parity enable forced on half
    for (int k = 0; k < 8; k++) begin
      r = lfsr(r);
      lc = {2'b00, r[5:2], k[1:0]} | (k[2] ? 8'h28 : 8'h00);
      wr(`UARTLC_ADDR_LCR, {8'h00, lc});
      r = lfsr(r);
      bits <= nb(lc);
      fq.push_back(frame_of(lc, r, 1'b0, 1'b1));
      wr(`UARTLC_ADDR_DATA, {8'h00, r});
      hold(1);
      for (int i = 0; i < 2000 && fq.size() > 0; i++) @(posedge clk_sys_i);
      hold(64);
    end
    check("frames left", 16'(fq.size()), 16'h0000);
    rd(`UARTLC_ADDR_IID, 16'h0002);
    rd(`UARTLC_ADDR_IID, 16'h0001);
    hold(1);
    $display("test transmit done");
    // break holds the pin low, clearing it restores idle high
    bits <= 4'h0;
    wr(`UARTLC_ADDR_LCR, 16'h0043);
    hold(4);
    check("break pin", {15'h0000, gpio_tx_o}, 16'h0000);
    wr(`UARTLC_ADDR_LCR, 16'h0003);
    hold(4);
    check("break pin", {15'h0000, gpio_tx_o}, 16'h0001);
    $display("test break done");
    // receive: good parity with two stops set, bad parity, stop bit low
    wr(`UARTLC_ADDR_CON1, 16'h0080);
    for (int j = 0; j < 3; j++) begin
      lc = (j == 0) ? 8'h1f : (j == 1) ? 8'h08 : 8'h02;
      wr(`UARTLC_ADDR_LCR, {8'h00, lc});
      hold(1);
      r = lfsr(r) | 8'h01;
      f = frame_of(lc, r, j == 1, j != 2);
      peer_u.send(f, nb(lc));
      hold(1);
      rd(`UARTLC_ADDR_STA, 16'h0061 | ((j == 0) ? 16'h0000 : 16'h0002 << j));
      rd(`UARTLC_ADDR_DATA, f & ((16'h0001 << (5 + lc[1:0])) - 16'h0001));
      rd(`UARTLC_ADDR_STA, 16'h0060);
      hold(1);
    end
    $display("test receive done");
    // loopback keeps the pin high and feeds the receiver internally
    wr(`UARTLC_ADDR_CON1, 16'h0090);
    wr(`UARTLC_ADDR_LCR, 16'h0003);
    wr(`UARTLC_ADDR_DATA, 16'h003c);
    for (int i = 0; i < 12; i++) begin
      hold(32);
      check("loop pin", {15'h0000, gpio_tx_o}, 16'h0001);
    end
    rd(`UARTLC_ADDR_STA, 16'h0061);
    rd(`UARTLC_ADDR_DATA, 16'h003c);
    hold(2);
    $display("test loopback done");
    close_out();
  end
endmodule // testbench
